/* File: shared/pulse_cmd_pkg.sv */
/*
 Constants shared by the position command front end: register map,
 field positions, reset values, limits, filter tick timing and states.
 Assumes a 100 MHz system clock.
*/
package pulse_cmd_pkg;
   localparam int CLK_NS = 10;
   localparam int TICK_NS = 100000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam int FRAC = 16;
   localparam logic [5:0] A_CTRL = 6'h00;
   localparam logic [5:0] A_LPF = 6'h04;
   localparam logic [5:0] A_MAVG = 6'h08;
   localparam logic [5:0] A_BAND = 6'h0C;
   localparam logic [5:0] A_NEAR = 6'h10;
   localparam logic [5:0] A_JOG = 6'h14;
   localparam logic [5:0] A_TARGET = 6'h18;
   localparam logic [5:0] A_STATUS = 6'h1C;
   localparam logic [5:0] A_COUNT = 6'h20;
   localparam logic [5:0] A_DEV = 6'h24;
   localparam logic [5:0] A_FILT = 6'h28;
   localparam int F_MODE = 0;
   localparam int F_SRC = 4;
   localparam int F_FMT = 5;
   localparam int F_POL = 7;
   localparam int F_COND = 8;
   localparam int F_INT = 10;
   localparam int F_PJOG = 11;
   localparam logic [3:0] MODE_POS = 4'h1;
   localparam logic [3:0] R_MODE = 4'h0;
   localparam logic [1:0] FMT_QUAD = 2'h0;
   localparam logic [1:0] FMT_PDIR = 2'h1;
   localparam logic [1:0] FMT_CWCCW = 2'h2;
   localparam logic [1:0] R_FMT = 2'h1;
   localparam logic [1:0] COND_FILT = 2'h1;
   localparam logic [1:0] COND_RAW = 2'h2;
   localparam logic [15:0] LPF_MAX = 16'h4E20;
   localparam logic [7:0] MAVG_MAX = 8'h80;
   localparam logic [13:0] BAND_MAX = 14'h2710;
   localparam logic [13:0] R_BAND = 14'h000A;
   localparam logic [14:0] R_NEAR = 15'h0064;
   typedef enum logic [1:0] {
      JOG_IDLE = 2'b00,
      JOG_PANEL = 2'b01
   } jog_state_t;
endpackage

/* File: rtl/pulse_decoder.sv */
/*
 Command pulse decoder: turns two pulse lines into forward and reverse
 step strobes for quadrature, pulse plus direction or CW/CCW trains.
 Assumes lines already selected, polarity-corrected and synchronous.
*/
`timescale 1ns/10ps
module pulse_decoder (
   input wire logic clk,
   input wire logic rst,
   input wire logic line_a,
   input wire logic line_b,
   input wire logic [1:0] fmt,
   output logic step_fwd,
   output logic step_rev
);
   logic a_r;
   logic b_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         a_r <= line_a;
         b_r <= line_b;
      end else begin
         a_r <= line_a;
         b_r <= line_b;
      end
   end

   wire a_edge = a_r ^ line_a;
   wire b_edge = b_r ^ line_b;
   wire a_rise = a_edge & line_a;
   wire b_rise = b_edge & line_b;
   wire same = line_a == line_b;
   // Both phases moving at once is a lost step, so it is dropped
   wire one_edge = a_edge ^ b_edge;
   wire q_fwd = one_edge & ((a_edge & !same) | (b_edge & same));
   wire q_rev = one_edge & ((a_edge & same) | (b_edge & !same));
   wire p_fwd = a_rise & !line_b;
   wire p_rev = a_rise & line_b;
   wire c_fwd = a_rise & !b_rise;
   wire c_rev = b_rise & !a_rise;

   assign step_fwd = (fmt == pulse_cmd_pkg::FMT_QUAD) ? q_fwd :
      (fmt == pulse_cmd_pkg::FMT_PDIR) ? p_fwd :
      (fmt == pulse_cmd_pkg::FMT_CWCCW) ? c_fwd : 1'b0;
   assign step_rev = (fmt == pulse_cmd_pkg::FMT_QUAD) ? q_rev :
      (fmt == pulse_cmd_pkg::FMT_PDIR) ? p_rev :
      (fmt == pulse_cmd_pkg::FMT_CWCCW) ? c_rev : 1'b0;
endmodule

/* File: rtl/moving_average.sv */
/*
 Moving average over the last 2**win_log position samples, one per tick.
 Assumes load is held while bypassed or when the window changes.
*/
`timescale 1ns/10ps
module moving_average #(
   parameter int W = 32,
   parameter int DEPTH_LOG = 7
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic load,
   input wire logic [2:0] win_log,
   input wire logic signed [W-1:0] sample,
   output logic signed [W-1:0] avg
);
   localparam int DEPTH = 1 << DEPTH_LOG;
   logic signed [W-1:0] hist [DEPTH];
   logic [DEPTH_LOG-1:0] wp_r;
   logic signed [W+DEPTH_LOG:0] sum_r;

   wire [DEPTH_LOG-1:0] rp = wp_r - DEPTH_LOG'(1 << win_log);
   wire signed [W+DEPTH_LOG:0] sum_nxt = sum_r + sample - hist[rp];
   wire signed [W+DEPTH_LOG:0] shifted = sum_r >>> win_log;
   assign avg = shifted[W-1:0];

   // Load primes every entry so the window starts full, not from zero
   always_ff @(posedge clk) begin
      if (rst || load) begin
         for (int i = 0; i < DEPTH; i++) begin
            hist[i] <= sample;
         end
         wp_r <= '0;
         sum_r <= (W+DEPTH_LOG+1)'(sample) <<< win_log;
      end else if (tick) begin
         hist[wp_r] <= sample;
         wp_r <= wp_r + 1'b1;
         sum_r <= sum_nxt;
      end
   end
endmodule

/* File: rtl/pulse_command_front_end.sv */
/*
 Position-mode command front end: pulse source selection and decoding,
 pulse inhibit, low-pass and moving-average smoothing, deviation,
 position-complete and near-position outputs, DI and panel jog.
 Assumes synchronous inputs, one-cycle encoder step strobes and a plain
 register port with read data one cycle after the read strobe.
*/
`timescale 1ns/10ps
// Notes on behaviour
// - Position control only while mode field is 1; resets 0, written only when stopped.
// - Source 0 takes low-speed terminal, 1 takes high-speed terminal.
// - Format 0 quadrature, 1 pulse plus direction (default), 2 CW/CCW.
// - Polarity 1 inverts both command lines, 0 passes them.
// - Pulse inhibit input holds the command count; counting resumes when released.
// - First-order low-pass filter, time 0 to 2000.0 ms, default 0.
// - Moving-average filter, time 0 to 12.8 ms, default 0.
// - A filter with time zero is bypassed completely.
// - Complete needs deviation under band; 1 adds filtered, 2 adds raw reference still.
// - Complete band 0 to 10000, default 10, writable while running.
// - Near threshold 1 to 32767, default 100, writable while running.
// - Near output only with internal position reference.
// - Deviation is command minus encoder movement; outputs assert below threshold.
// - DI jog runs forward or reverse at jog speed.
// - Panel jog runs on up/down keys, leaves on set or menu key.
module pulse_command_front_end #(
   parameter int W = 32,
   parameter int TICK_CYC = pulse_cmd_pkg::TICK_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [5:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic lo_pulse_a,
   input wire logic lo_pulse_b,
   input wire logic hi_pulse_a,
   input wire logic hi_pulse_b,
   input wire logic pulse_inhibit_input,
   input wire logic enc_fwd,
   input wire logic enc_rev,
   input wire logic motor_stopped,
   input wire logic jog_forward_input,
   input wire logic jog_reverse_input,
   input wire logic key_up,
   input wire logic key_down,
   input wire logic key_set,
   input wire logic key_menu,
   output logic position_complete_output,
   output logic near_output,
   output logic position_mode,
   output logic jog_run_fwd,
   output logic jog_run_rev,
   output logic [15:0] jog_speed_out
);
   localparam int FR = pulse_cmd_pkg::FRAC;

   function automatic logic [3:0] msb_of(input logic [15:0] v);
      msb_of = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (v[i]) begin
            msb_of = 4'(i);
         end
      end
   endfunction

   // ***************************************
   // Registers
   // ***************************************
   logic [3:0] control_mode_select_r;
   logic pulse_source_select_r;
   logic [1:0] pulse_format_select_r;
   logic pulse_polarity_select_r;
   logic [1:0] complete_condition_select_r;
   logic int_ref_sel_r;
   logic [15:0] lowpass_filter_time_r;
   logic [7:0] moving_average_time_r;
   logic [13:0] complete_band_r;
   logic [14:0] near_threshold_r;
   logic [15:0] jog_speed_setting_r;
   logic signed [W-1:0] int_target_r;

   wire wr_ctrl = wr && addr == pulse_cmd_pkg::A_CTRL;
   wire wr_lpf = wr && addr == pulse_cmd_pkg::A_LPF;
   wire wr_mavg = wr && addr == pulse_cmd_pkg::A_MAVG;
   wire wr_band = wr && addr == pulse_cmd_pkg::A_BAND;
   wire wr_near = wr && addr == pulse_cmd_pkg::A_NEAR;
   wire wr_jog = wr && addr == pulse_cmd_pkg::A_JOG;
   wire wr_tgt = wr && addr == pulse_cmd_pkg::A_TARGET;
   wire stop_ok = motor_stopped;
   wire panel_jog_entry = wr_ctrl && wdata[pulse_cmd_pkg::F_PJOG];

   wire [15:0] lpf_nxt = (wdata[15:0] > pulse_cmd_pkg::LPF_MAX) ?
      pulse_cmd_pkg::LPF_MAX : wdata[15:0];
   wire [7:0] mavg_nxt = (wdata[7:0] > pulse_cmd_pkg::MAVG_MAX) ?
      pulse_cmd_pkg::MAVG_MAX : wdata[7:0];
   wire [13:0] band_nxt = (wdata[13:0] > pulse_cmd_pkg::BAND_MAX) ?
      pulse_cmd_pkg::BAND_MAX : wdata[13:0];
   wire [14:0] near_nxt = (wdata[14:0] == 15'h0000) ? 15'h0001 : wdata[14:0];

   // Mode and pulse settings only change at standstill
   always_ff @(posedge clk) begin
      if (rst) begin
         control_mode_select_r <= pulse_cmd_pkg::R_MODE;
         pulse_source_select_r <= 1'b0;
         pulse_format_select_r <= pulse_cmd_pkg::R_FMT;
         pulse_polarity_select_r <= 1'b0;
         complete_condition_select_r <= 2'h0;
         int_ref_sel_r <= 1'b0;
      end else if (wr_ctrl && stop_ok) begin
         control_mode_select_r <= wdata[pulse_cmd_pkg::F_MODE +: 4];
         pulse_source_select_r <= wdata[pulse_cmd_pkg::F_SRC];
         pulse_format_select_r <= wdata[pulse_cmd_pkg::F_FMT +: 2];
         pulse_polarity_select_r <= wdata[pulse_cmd_pkg::F_POL];
         complete_condition_select_r <= wdata[pulse_cmd_pkg::F_COND +: 2];
         int_ref_sel_r <= wdata[pulse_cmd_pkg::F_INT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lowpass_filter_time_r <= 16'h0000;
         moving_average_time_r <= 8'h00;
      end else if (stop_ok) begin
         if (wr_lpf) begin
            lowpass_filter_time_r <= lpf_nxt;
         end
         if (wr_mavg) begin
            moving_average_time_r <= mavg_nxt;
         end
      end
   end

   // Band and near threshold are live while running
   always_ff @(posedge clk) begin
      if (rst) begin
         complete_band_r <= pulse_cmd_pkg::R_BAND;
         near_threshold_r <= pulse_cmd_pkg::R_NEAR;
         jog_speed_setting_r <= 16'h0000;
         int_target_r <= '0;
      end else begin
         if (wr_band) begin
            complete_band_r <= band_nxt;
         end
         if (wr_near) begin
            near_threshold_r <= near_nxt;
         end
         if (wr_jog) begin
            jog_speed_setting_r <= wdata[15:0];
         end
         if (wr_tgt) begin
            int_target_r <= wdata[W-1:0];
         end
      end
   end

   // ***************************************
   // Pulse input and counting
   // ***************************************
   wire pos_mode = control_mode_select_r == pulse_cmd_pkg::MODE_POS;
   wire raw_a = pulse_source_select_r ? hi_pulse_a : lo_pulse_a;
   wire raw_b = pulse_source_select_r ? hi_pulse_b : lo_pulse_b;
   wire line_a = raw_a ^ pulse_polarity_select_r;
   wire line_b = raw_b ^ pulse_polarity_select_r;
   wire step_fwd;
   wire step_rev;

   pulse_decoder u_dec (
      .clk(clk),
      .rst(rst),
      .line_a(line_a),
      .line_b(line_b),
      .fmt(pulse_format_select_r),
      .step_fwd(step_fwd),
      .step_rev(step_rev)
   );

   logic signed [W-1:0] pulse_count_r;
   logic signed [W-1:0] motor_pos_r;
   wire count_en = pos_mode && !int_ref_sel_r && !pulse_inhibit_input;

   always_ff @(posedge clk) begin
      if (rst) begin
         pulse_count_r <= '0;
      end else if (count_en && step_fwd) begin
         pulse_count_r <= pulse_count_r + 1'b1;
      end else if (count_en && step_rev) begin
         pulse_count_r <= pulse_count_r - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         motor_pos_r <= '0;
      end else if (enc_fwd && !enc_rev) begin
         motor_pos_r <= motor_pos_r + 1'b1;
      end else if (enc_rev && !enc_fwd) begin
         motor_pos_r <= motor_pos_r - 1'b1;
      end
   end

   // ***************************************
   // Filter tick and smoothing
   // ***************************************
   logic [15:0] tick_cnt_r;
   wire tick = tick_cnt_r == 16'(TICK_CYC - 1);

   always_ff @(posedge clk) begin
      if (rst || tick) begin
         tick_cnt_r <= 16'h0000;
      end else begin
         tick_cnt_r <= tick_cnt_r + 1'b1;
      end
   end

   wire signed [W-1:0] cmd_raw = int_ref_sel_r ? int_target_r : pulse_count_r;
   logic signed [W+FR-1:0] lpf_acc_r;
   wire lpf_bypass = lowpass_filter_time_r == 16'h0000;
   wire [3:0] lpf_shift = msb_of(lowpass_filter_time_r);
   wire signed [W+FR-1:0] lpf_in = {cmd_raw, FR'(0)};
   wire signed [W+FR-1:0] lpf_err = lpf_in - lpf_acc_r;

   // Power-of-two gain keeps the filter free of a divider
   always_ff @(posedge clk) begin
      if (rst || lpf_bypass) begin
         lpf_acc_r <= lpf_in;
      end else if (tick) begin
         lpf_acc_r <= lpf_acc_r + (lpf_err >>> lpf_shift);
      end
   end

   wire signed [W-1:0] lpf_out = lpf_bypass ? cmd_raw : lpf_acc_r[W+FR-1:FR];
   wire mavg_bypass = moving_average_time_r == 8'h00;
   // Window of the write itself, so priming matches the new scale
   wire [7:0] mavg_win = (wr_mavg && stop_ok) ? mavg_nxt : moving_average_time_r;
   wire [3:0] mavg_msb = msb_of({8'h00, mavg_win});
   wire signed [W-1:0] mavg_out;

   moving_average #(
      .W(W),
      .DEPTH_LOG(7)
   ) u_mavg (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .load(mavg_bypass || wr_mavg),
      .win_log(mavg_msb[2:0]),
      .sample(lpf_out),
      .avg(mavg_out)
   );

   // ***************************************
   // Deviation and completion
   // ***************************************
   logic signed [W-1:0] filt_ref_r;
   logic signed [W-1:0] raw_at_tick_r;
   logic signed [W-1:0] filt_at_tick_r;
   logic raw_still_r;
   logic filt_still_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         filt_ref_r <= '0;
         raw_at_tick_r <= '0;
         filt_at_tick_r <= '0;
         raw_still_r <= 1'b1;
         filt_still_r <= 1'b1;
      end else begin
         filt_ref_r <= mavg_bypass ? lpf_out : mavg_out;
         if (tick) begin
            raw_at_tick_r <= cmd_raw;
            filt_at_tick_r <= filt_ref_r;
            raw_still_r <= cmd_raw == raw_at_tick_r;
            filt_still_r <= filt_ref_r == filt_at_tick_r;
         end
      end
   end

   wire signed [W-1:0] deviation = filt_ref_r - motor_pos_r;
   wire [W-1:0] abs_dev = deviation[W-1] ? W'(-deviation) : W'(deviation);
   wire in_band = abs_dev < W'(complete_band_r);
   wire in_near = abs_dev < W'(near_threshold_r);
   wire cond_ok = (complete_condition_select_r == pulse_cmd_pkg::COND_FILT) ?
      filt_still_r : (complete_condition_select_r == pulse_cmd_pkg::COND_RAW) ?
      raw_still_r : 1'b1;

   // ***************************************
   // Jog control
   // ***************************************
   pulse_cmd_pkg::jog_state_t jog_state_r;
   pulse_cmd_pkg::jog_state_t jog_state_nxt;

   always_comb begin
      jog_state_nxt = jog_state_r;
      unique case (jog_state_r)
         pulse_cmd_pkg::JOG_IDLE: begin
            if (panel_jog_entry && !pos_mode) begin
               jog_state_nxt = pulse_cmd_pkg::JOG_PANEL;
            end
         end
         pulse_cmd_pkg::JOG_PANEL: begin
            if (key_set || key_menu || pos_mode) begin
               jog_state_nxt = pulse_cmd_pkg::JOG_IDLE;
            end
         end
         default: begin
            jog_state_nxt = pulse_cmd_pkg::JOG_IDLE;
         end
      endcase
   end

   wire in_panel = jog_state_r == pulse_cmd_pkg::JOG_PANEL;
   wire want_fwd = in_panel ? key_up && !key_down :
      jog_forward_input && !jog_reverse_input;
   wire want_rev = in_panel ? key_down && !key_up :
      jog_reverse_input && !jog_forward_input;

   // ***************************************
   // Outputs and read port
   // ***************************************
   wire [31:0] status = {26'h0, filt_still_r, raw_still_r, in_panel,
      pos_mode, near_output, position_complete_output};
   wire [31:0] ctrl_rd = {21'h0, int_ref_sel_r, complete_condition_select_r,
      pulse_polarity_select_r, pulse_format_select_r, pulse_source_select_r,
      control_mode_select_r};
   wire [31:0] rmux =
      (addr == pulse_cmd_pkg::A_CTRL) ? ctrl_rd :
      (addr == pulse_cmd_pkg::A_LPF) ? {16'h0, lowpass_filter_time_r} :
      (addr == pulse_cmd_pkg::A_MAVG) ? {24'h0, moving_average_time_r} :
      (addr == pulse_cmd_pkg::A_BAND) ? {18'h0, complete_band_r} :
      (addr == pulse_cmd_pkg::A_NEAR) ? {17'h0, near_threshold_r} :
      (addr == pulse_cmd_pkg::A_JOG) ? {16'h0, jog_speed_setting_r} :
      (addr == pulse_cmd_pkg::A_TARGET) ? 32'(int_target_r) :
      (addr == pulse_cmd_pkg::A_STATUS) ? status :
      (addr == pulse_cmd_pkg::A_COUNT) ? 32'(pulse_count_r) :
      (addr == pulse_cmd_pkg::A_DEV) ? 32'(deviation) :
      (addr == pulse_cmd_pkg::A_FILT) ? 32'(filt_ref_r) : 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (rst) begin
         jog_state_r <= pulse_cmd_pkg::JOG_IDLE;
         rdata <= 32'h0000_0000;
         position_complete_output <= 1'b0;
         near_output <= 1'b0;
         position_mode <= 1'b0;
         jog_run_fwd <= 1'b0;
         jog_run_rev <= 1'b0;
         jog_speed_out <= 16'h0000;
      end else begin
         jog_state_r <= jog_state_nxt;
         rdata <= rd ? rmux : 32'h0000_0000;
         position_complete_output <= pos_mode && in_band && cond_ok;
         near_output <= pos_mode && int_ref_sel_r && in_near;
         position_mode <= pos_mode;
         jog_run_fwd <= !pos_mode && want_fwd;
         jog_run_rev <= !pos_mode && want_rev;
         jog_speed_out <= (!pos_mode && (want_fwd || want_rev)) ?
            jog_speed_setting_r : 16'h0000;
      end
   end

   // ***************************************
   // Assertions
   // ***************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_mode_stop;
      wr_ctrl && !motor_stopped |=> $stable(control_mode_select_r);
   endproperty
   a_mode_stop: assert property (p_mode_stop) else $error("mode changed while moving");

   property p_no_count;
      !pos_mode || pulse_inhibit_input |=> pulse_count_r == $past(pulse_count_r);
   endproperty
   a_no_count: assert property (p_no_count) else $error("count moved while held");

   property p_count_up;
      count_en && step_fwd |=> pulse_count_r == $past(pulse_count_r) + 1;
   endproperty
   a_count_up: assert property (p_count_up) else $error("forward step not counted");

   property p_bypass;
      lpf_bypass && mavg_bypass ##1 lpf_bypass && mavg_bypass |-> filt_ref_r == $past(cmd_raw);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypassed command filtered");

   property p_complete;
      position_complete_output |-> $past(in_band && pos_mode);
   endproperty
   a_complete: assert property (p_complete) else $error("complete outside band");

   property p_cond_raw;
      position_complete_output && $past(complete_condition_select_r) == 2'h2 |-> $past(raw_still_r);
   endproperty
   a_cond_raw: assert property (p_cond_raw) else $error("complete with raw moving");

   property p_near_int;
      near_output |-> $past(int_ref_sel_r);
   endproperty
   a_near_int: assert property (p_near_int) else $error("near without internal ref");

   property p_panel_exit;
      in_panel && (key_set || key_menu) |=> !in_panel ##1 !jog_run_fwd && !jog_run_rev;
   endproperty
   a_panel_exit: assert property (p_panel_exit) else $error("panel jog not left");

   property p_di_jog;
      !pos_mode && !in_panel && jog_forward_input && !jog_reverse_input |=>
         jog_run_fwd && jog_speed_out == $past(jog_speed_setting_r);
   endproperty
   a_di_jog: assert property (p_di_jog) else $error("DI jog not forward");

   property p_band_live;
      wr_band && wdata[13:0] == 14'h0000 |=> ##1 !position_complete_output;
   endproperty
   a_band_live: assert property (p_band_live) else $error("zero band still complete");

   c_complete: cover property (pos_mode ##1 position_complete_output);
   c_panel: cover property (in_panel ##[1:20] jog_run_rev);
   c_inhibit: cover property (pos_mode && pulse_inhibit_input && step_fwd);
endmodule

/* File: dv/pulse_host_model.sv */
/*
 Host controller model driving one pulse terminal pair.
 Assumes one bench process calls step and sets inv only outside position mode.
*/
`timescale 1ns/10ps
module pulse_host_model (
   input wire logic clk,
   output logic line_a,
   output logic line_b
);
   // ***************
   // Pulse generation
   // ***************
   logic a = 1'b0, b = 1'b0, inv = 1'b0;
   logic [1:0] q = 2'h0;
   assign line_a = a ^ inv;
   assign line_b = b ^ inv;
   task automatic mv(input logic na, input logic nb);
      @(posedge clk);
      a <= na;
      b <= nb;
      repeat (2) @(posedge clk);
   endtask
   task automatic step(input logic [1:0] fmt, input logic rev);
      if (fmt == 2'h0) begin
         q = rev ? q - 2'h1 : q + 2'h1;
         mv(q[1] ^ q[0], q[1]);
      end else if (fmt == 2'h1) begin
         q = 2'h0;
         mv(1'b0, rev);
         mv(1'b1, rev);
         mv(1'b0, rev);
      end else begin
         q = 2'h0;
         mv(!rev, rev);
         mv(1'b0, 1'b0);
      end
   endtask
endmodule

/* File: dv/pulse_command_front_end_tb_top.sv */
/*
 Bench for the position command front end: register master, two host models,
 encoder strobes, jog inputs and keys.
 Assumes the filter tick shortened to 8 cycles.
*/
`timescale 1ns/10ps
module pulse_command_front_end_tb_top;
   // ***************
   // Harness
   // ***************
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, inh = 1'b0, ef = 1'b0, er = 1'b0, stp = 1'b1;
   logic jfi = 1'b0, jri = 1'b0, ku = 1'b0, kd = 1'b0, ks = 1'b0, km = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic lo_a, lo_b, hi_a, hi_b, pc, nr, pm, jf, jr;
   logic [15:0] js;
   int error_cnt = 0, n_tests = 0, cnt = 0, mot = 0;
   pulse_host_model i_pulse_host_model_lo (.clk(clk), .line_a(lo_a), .line_b(lo_b));
   pulse_host_model i_pulse_host_model_hi (.clk(clk), .line_a(hi_a), .line_b(hi_b));
   pulse_command_front_end #(.W(32), .TICK_CYC(8)) i_pulse_command_front_end (.clk(clk), .rst(rst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .lo_pulse_a(lo_a), .lo_pulse_b(lo_b),
      .hi_pulse_a(hi_a), .hi_pulse_b(hi_b), .pulse_inhibit_input(inh), .enc_fwd(ef), .enc_rev(er),
      .motor_stopped(stp), .jog_forward_input(jfi), .jog_reverse_input(jri), .key_up(ku), .key_down(kd),
      .key_set(ks), .key_menu(km), .position_complete_output(pc), .near_output(nr), .position_mode(pm),
      .jog_run_fwd(jf), .jog_run_rev(jr), .jog_speed_out(js));
   initial forever #5 clk = ~clk;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wreg(input logic [5:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [5:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   function automatic logic [31:0] cw(logic [3:0] m, logic s, logic [1:0] f, logic p, logic i);
      return {21'h0, i, 2'h0, p, f, s, m};
   endfunction
   // ***************
   // Scenarios
   // ***************
   task automatic t_reset;
      rreg(6'h00);
      chk("ctrl", d, 32'h20);
      rreg(6'h0C);
      chk("band", d, 32'hA);
      rreg(6'h10);
      chk("near", d, 32'h64);
      stp <= 1'b0;
      wreg(6'h00, 32'h21);
      w(3);
      chk("mode locked", pm, 1'b0);
      stp <= 1'b1;
      $display("t_reset done");
   endtask
   task automatic t_formats;
      for (int p = 0; p < 2; p++) begin
         for (int f = 0; f < 3; f++) begin
            wreg(6'h00, cw(4'h0, 1'b0, 2'(f), 1'(p), 1'b0));
            w(2);
            i_pulse_host_model_lo.inv = 1'(p);
            wreg(6'h00, cw(4'h1, 1'b0, 2'(f), 1'(p), 1'b0));
            repeat (3) i_pulse_host_model_lo.step(2'(f), 1'b0);
            i_pulse_host_model_lo.step(2'(f), 1'b1);
            cnt += 2;
            rreg(6'h20);
            chk("count", d, 32'(cnt));
         end
      end
      wreg(6'h00, cw(4'h0, 1'b1, 2'h1, 1'b0, 1'b0));
      w(2);
      i_pulse_host_model_lo.inv = 1'b0;
      wreg(6'h00, cw(4'h1, 1'b1, 2'h1, 1'b0, 1'b0));
      repeat (2) i_pulse_host_model_lo.step(2'h1, 1'b0);
      i_pulse_host_model_hi.step(2'h1, 1'b0);
      rreg(6'h20);
      chk("hi source", d, 32'(++cnt));
      inh <= 1'b1;
      i_pulse_host_model_hi.step(2'h1, 1'b0);
      rreg(6'h20);
      chk("inhibited", d, 32'(cnt));
      inh <= 1'b0;
      i_pulse_host_model_hi.step(2'h1, 1'b0);
      rreg(6'h20);
      chk("resumed", d, 32'(++cnt));
      $display("t_formats done");
   endtask
   task automatic t_complete;
      rreg(6'h28);
      chk("filt bypass", d, 32'(cnt));
      chk("complete far", pc, 1'b0);
      mot = cnt - 8;
      repeat (mot) begin
         @(posedge clk);
         ef <= 1'b1;
         @(posedge clk);
         ef <= 1'b0;
      end
      w(4);
      chk("complete", pc, 1'b1);
      chk("near ext", nr, 1'b0);
      chk("pos mode", pm, 1'b1);
      rreg(6'h24);
      chk("deviation", d, 32'h8);
      wreg(6'h0C, 32'h0);
      w(3);
      chk("band zero", pc, 1'b0);
      wreg(6'h0C, 32'h8);
      w(3);
      chk("band strict", pc, 1'b0);
      wreg(6'h0C, 32'hA);
      for (int c = 1; c < 3; c++) begin
         wreg(6'h00, cw(4'h1, 1'b1, 2'h1, 1'b0, 1'b0) | 32'(c << 8));
         w(30);
         chk("complete cond", pc, 1'b1);
      end
      wreg(6'h18, 32'(mot + 20));
      wreg(6'h00, cw(4'h1, 1'b1, 2'h1, 1'b0, 1'b1));
      w(4);
      chk("near int", nr, 1'b1);
      chk("complete off", pc, 1'b0);
      wreg(6'h10, 32'h14);
      w(3);
      chk("near strict", nr, 1'b0);
      $display("t_complete done");
   endtask
   task automatic t_filters;
      wreg(6'h04, 32'hFFFF);
      rreg(6'h04);
      chk("lpf clamp", d, 32'h4E20);
      wreg(6'h18, 32'(mot + 40));
      w(20);
      rreg(6'h28);
      chk("lpf lag", 32'(d === 32'(mot + 40)), 32'h0);
      wreg(6'h04, 32'h0);
      wreg(6'h08, 32'hFF);
      rreg(6'h08);
      chk("mavg clamp", d, 32'h80);
      wreg(6'h18, 32'(mot + 84));
      rreg(6'h28);
      chk("mavg lag", 32'(d === 32'(mot + 84)), 32'h0);
      w(1100);
      rreg(6'h28);
      chk("mavg settle", d, 32'(mot + 84));
      wreg(6'h08, 32'h0);
      wreg(6'h18, 32'h5);
      rreg(6'h28);
      chk("mavg bypass", d, 32'h5);
      $display("t_filters done");
   endtask
   task automatic t_jog;
      wreg(6'h00, 32'h0);
      wreg(6'h14, 32'h1234);
      jfi <= 1'b1;
      w(3);
      chk("di jog fwd", {jf, jr, js}, 32'h21234);
      jfi <= 1'b0;
      jri <= 1'b1;
      w(3);
      chk("di jog rev", {jf, jr}, 32'h1);
      jri <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         wreg(6'h00, 32'h800);
         ku <= 1'b1;
         w(3);
         chk("panel up", {jf, jr}, 32'h2);
         ku <= 1'b0;
         kd <= 1'b1;
         w(3);
         chk("panel down", {jf, jr}, 32'h1);
         ks <= (k == 0);
         km <= (k == 1);
         w(4);
         chk("panel exit", {jf, jr}, 32'h0);
         {kd, ks, km} <= 3'h0;
         rreg(6'h1C);
         chk("panel state", d[3], 1'b0);
      end
      $display("t_jog done");
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #400000;
      error_cnt++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_formats();
      t_complete();
      t_filters();
      t_jog();
      stop_test();
   end
endmodule
